// file: deil_channel.sv
`timescale 1ns/1ns
`default_nettype none
module deil_channel (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_n,
  input  wire logic level_sense,
  input  wire logic vec_ack,
  input  wire logic soft_ack,
  output logic      pin_sync,
  output logic      fall,
  output logic      pending
);
  logic s1_r, s1_nxt;
  logic s2_r, s2_nxt;
  logic prev_r, prev_nxt;
  logic latch_r, latch_nxt;
  logic [deil_pkg::SYNC_FILL-1:0] arm_r, arm_nxt;

  always_comb
  begin
    s1_nxt   = pin_n;
    s2_nxt   = s1_r;
    prev_nxt = s2_r;
    arm_nxt  = {arm_r[deil_pkg::SYNC_FILL-2:0], 1'b1};
    // set beats a clear arriving in the same cycle
    latch_nxt = fall | (latch_r & ~(vec_ack | soft_ack));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r    <= deil_pkg::PIN_IDLE;
      s2_r    <= deil_pkg::PIN_IDLE;
      prev_r  <= deil_pkg::PIN_IDLE;
      latch_r <= 1'b0;
      arm_r   <= '0;
    end
    else
    begin
      arm_r   <= arm_nxt;
      s1_r    <= s1_nxt;
      s2_r    <= s2_nxt;
      prev_r  <= prev_nxt;
      latch_r <= latch_nxt;
    end
  end

  // a pin already low at reset release is not an edge: wait until prev holds a real sample
  assign fall     = prev_r & ~s2_r & arm_r[deil_pkg::SYNC_FILL-1];
  assign pin_sync = s2_r;
  // in level mode a low level keeps the request alive after an acknowledge
  assign pending  = latch_r | (level_sense & ~s2_r);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ack_then_edge;
    soft_ack ##1 fall;
  endsequence

  edge_set_a: assert property (fall |=> latch_r)
    else $error("falling edge did not set latch");
  ack_clear_a: assert property ((vec_ack || soft_ack) && !fall |=> !latch_r)
    else $error("acknowledge did not clear latch");
  level_hold_a: assert property (level_sense && !s2_r |-> pending)
    else $error("low level in level mode not pending");
  new_edge_a: assert property (ack_then_edge |=> latch_r && pending)
    else $error("edge after acknowledge lost");
  edge_mode_a: assert property (!level_sense && !latch_r |-> !pending)
    else $error("edge mode pending without latch");
endmodule
`default_nettype wire

// file: deil_pkg.sv
// Contract
// - a falling edge on a channel pin sets that channel's latch.
// - a vector-fetch acknowledge clears only the latch of its own channel.
// - software writing one to a channel's acknowledge bit clears its latch.
// - reset clears every latch whatever level the pins show.
// - in edge-only mode the latch holds until its own channel's acknowledge or reset.
// - in edge-and-level mode the request stays until acknowledged and pin high.
// - reset clears latch and sensitivity select, even with the pin held low.
// - a set mask bit withholds the request from the priority logic.
// - the pending flag reads the request regardless of the mask.
// - a falling edge after a software acknowledge latches a new request.
// - the acknowledge bit is write-only and reads as zero.
// - the mask bit is read/write, one disables, reset clears it.
// - the sensitivity select is read/write, one adds low level, reset clears.
// - channel b pullup is off when its disable bit is one; channel a always on.
// - in break state software acknowledge works only with break clear enable set.
// - a latch cleared during break stays cleared after break ends.
// - channel a pin level goes to the branch-test logic, channel b never.
// - the processor global interrupt mask also suppresses external requests.
// - bits: select 0, mask 1, acknowledge 2, pending 3, b pullup-disable 6.
package deil_pkg;
  localparam int          ADDR_W    = 12;
  localparam int          REG_W     = 8;
  localparam int          DATA_W    = 32;
  localparam int          NCH       = 2;
  localparam int          CH_A      = 0;
  localparam int          CH_B      = 1;
  // printed offsets are register indices; byte address is four times that
  localparam logic [7:0]  IDX_B     = 8'h1c;
  localparam logic [7:0]  IDX_A     = 8'h1e;
  localparam logic [ADDR_W-1:0] ADDR_B = {2'h0, IDX_B, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_A = {2'h0, IDX_A, 2'h0};
  localparam int          BIT_MODE  = 0;
  localparam int          BIT_MASK  = 1;
  localparam int          BIT_ACK   = 2;
  localparam int          BIT_FLAG  = 3;
  localparam int          BIT_PUD   = 6;
  localparam logic        PIN_IDLE  = 1'b1;
  // edges after reset release before the edge detector trusts its samples
  localparam int          SYNC_FILL = 3;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  typedef struct packed {
    logic mask;
    logic level_sense;
  } deil_chan_ctrl_s;

  localparam deil_chan_ctrl_s CTRL_RESET = '{mask: 1'b0, level_sense: 1'b0};
endpackage

// file: deil_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module deil_src_model (
  input  wire logic       pclk,
  input  wire logic [1:0] hold_low,
  output logic            pin_a,
  output logic            pin_b
);
  // pullup enables are not modelled: a released line reads high even while b's pullup is disabled
  initial
  begin
    pin_a = 1'b1;
    pin_b = 1'b1;
  end
  always @(posedge pclk)
  begin
    pin_a <= ~hold_low[0];
    pin_b <= ~hold_low[1];
  end
endmodule
`default_nettype wire

// file: deil_top.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module deil_top #(
  parameter int ADDR_W = deil_pkg::ADDR_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ext_int_pin_a,
  input  wire logic              ext_int_pin_b,
  input  wire logic              vector_ack_a,
  input  wire logic              vector_ack_b,
  input  wire logic              break_state,
  input  wire logic              break_clear_enable,
  input  wire logic              cpu_int_mask,
  output logic                   irq_request_a,
  output logic                   irq_request_b,
  output logic                   pin_level_a,
  output logic                   pullup_en_a,
  output logic                   pullup_en_b
);
  localparam int NCH = deil_pkg::NCH;
  localparam int CA  = deil_pkg::CH_A;
  localparam int CB  = deil_pkg::CH_B;

  deil_pkg::deil_chan_ctrl_s ctrl_r [NCH];
  deil_pkg::deil_chan_ctrl_s ctrl_nxt [NCH];
  logic                      pud_b_r;
  logic                      pud_b_nxt;
  logic [31:0]               prdata_r;
  logic [31:0]               prdata_nxt;
  logic [NCH-1:0]            irq_r;
  logic [NCH-1:0]            irq_nxt;
  logic                      pin_level_a_r;
  logic                      pin_level_a_nxt;

  logic [NCH-1:0]            pins_n;
  logic [NCH-1:0]            vec_ack;
  logic [NCH-1:0]            soft_ack;
  logic [NCH-1:0]            pin_sync;
  logic [NCH-1:0]            fall;
  logic [NCH-1:0]            pending;
  logic [NCH-1:0]            sel;
  logic                      hit;
  logic                      setup;
  logic                      access;
  logic                      wr_en;
  logic                      ack_allowed;

  assign pins_n  = {ext_int_pin_b, ext_int_pin_a};
  assign vec_ack = {vector_ack_b, vector_ack_a};

  // address decode
  assign sel[CA] = (paddr == deil_pkg::ADDR_A);
  assign sel[CB] = (paddr == deil_pkg::ADDR_B);
  assign hit     = |sel;
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  // zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;
  assign wr_en   = access & pwrite & pready;

  // acknowledges written in break are dropped unless enabled; a latch
  // cleared then just stays cleared, nothing restores it afterwards
  assign ack_allowed = ~break_state | break_clear_enable;

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      assign soft_ack[g] = wr_en & sel[g] & pwdata[deil_pkg::BIT_ACK]
                           & ack_allowed;
      deil_channel u_ch (
        .pclk        (pclk),
        .presetn     (presetn),
        .pin_n       (pins_n[g]),
        .level_sense (ctrl_r[g].level_sense),
        .vec_ack     (vec_ack[g]),
        .soft_ack    (soft_ack[g]),
        .pin_sync    (pin_sync[g]),
        .fall        (fall[g]),
        .pending     (pending[g])
      );
    end
  endgenerate

  // control registers
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      ctrl_nxt[i] = ctrl_r[i];
      if (wr_en && sel[i])
      begin
        ctrl_nxt[i].mask        = pwdata[deil_pkg::BIT_MASK];
        ctrl_nxt[i].level_sense = pwdata[deil_pkg::BIT_MODE];
      end
    end
    pud_b_nxt = pud_b_r;
    if (wr_en && sel[CB])
    begin
      pud_b_nxt = pwdata[deil_pkg::BIT_PUD];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        ctrl_r[i] <= deil_pkg::CTRL_RESET;
      end
      pud_b_r <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        ctrl_r[i] <= ctrl_nxt[i];
      end
      pud_b_r <= pud_b_nxt;
    end
  end

  // read data, captured in the setup cycle so it is ready for access
  always_comb
  begin
    logic [deil_pkg::REG_W-1:0] rd;
    rd = deil_pkg::REG_RESET;
    prdata_nxt = prdata_r;
    for (int i = 0; i < NCH; i++)
    begin
      if (sel[i])
      begin
        rd[deil_pkg::BIT_MODE] = ctrl_r[i].level_sense;
        rd[deil_pkg::BIT_MASK] = ctrl_r[i].mask;
        rd[deil_pkg::BIT_FLAG] = pending[i];
      end
    end
    // acknowledge bit and all other bits except b's pullup-disable stay zero on read
    if (sel[CB])
    begin
      rd[deil_pkg::BIT_PUD] = pud_b_r;
    end
    if (setup && !pwrite)
    begin
      prdata_nxt = {{(32 - deil_pkg::REG_W){1'b0}}, rd};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // requests to the priority logic, plus branch-test level
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      irq_nxt[i] = pending[i] & ~ctrl_r[i].mask & ~cpu_int_mask;
    end
    // only channel a feeds the branch-test path
    pin_level_a_nxt = pin_sync[CA];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_r         <= '0;
      pin_level_a_r <= deil_pkg::PIN_IDLE;
    end
    else
    begin
      irq_r         <= irq_nxt;
      pin_level_a_r <= pin_level_a_nxt;
    end
  end

  assign irq_request_a = irq_r[CA];
  assign irq_request_b = irq_r[CB];
  assign pin_level_a   = pin_level_a_r;
  assign pullup_en_a   = 1'b1;
  assign pullup_en_b   = ~pud_b_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rd_setup_a;
    psel && !penable && !pwrite && paddr == deil_pkg::ADDR_A;
  endsequence

  sequence rd_setup_b;
    psel && !penable && !pwrite && paddr == deil_pkg::ADDR_B;
  endsequence

  sequence wr_reg_b;
    psel && penable && pwrite && paddr == deil_pkg::ADDR_B;
  endsequence

  mask_gate_a: assert property (
    irq_request_a |-> $past(pending[CA] && !ctrl_r[CA].mask))
    else $error("request a presented while masked or idle");

  global_mask_a: assert property (
    cpu_int_mask |=> !irq_request_a && !irq_request_b)
    else $error("request passed global mask");

  flag_read_a: assert property (
    rd_setup_a |=> prdata[deil_pkg::BIT_FLAG] == $past(pending[CA]))
    else $error("pending flag a read wrong");

  ack_zero_a: assert property (
    rd_setup_b |=> prdata[deil_pkg::BIT_ACK] == 1'b0 && prdata[7] == 1'b0)
    else $error("acknowledge bit read nonzero");

  brk_block_a: assert property (
    break_state && !break_clear_enable |-> soft_ack == '0)
    else $error("acknowledge acted during break");

  pud_write_a: assert property (
    wr_reg_b ##0 pwdata[deil_pkg::BIT_PUD] |=> !pullup_en_b && pullup_en_a)
    else $error("pullup disable not applied");

  mode_write_a: assert property (
    wr_reg_b |=> ctrl_r[CB].level_sense == $past(pwdata[deil_pkg::BIT_MODE]))
    else $error("select b write not stored");

  soft_clear_a: assert property (
    soft_ack[CA] && !fall[CA] && !ctrl_r[CA].level_sense && !pwdata[deil_pkg::BIT_MODE]
    |=> !pending[CA])
    else $error("software acknowledge did not clear a");

  unmapped_a: assert property (
    psel && penable && !hit |-> pslverr && pready)
    else $error("unmapped access not flagged");

  mask_rw_a: assert property (
    wr_reg_b |=> ctrl_r[CB].mask == $past(pwdata[deil_pkg::BIT_MASK]))
    else $error("mask b write not stored");
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  w;
    logic [7:0]  e;
    logic        pu;
  } deil_row_s;
  localparam logic [11:0] a_adr = deil_pkg::ADDR_A;
  localparam logic [11:0] b_adr = deil_pkg::ADDR_B;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  low = 2'h0;
  logic        pin_a;
  logic        pin_b;
  logic        vack_a = 1'b0;
  logic        vack_b = 1'b0;
  logic        brk = 1'b0;
  logic        bce = 1'b0;
  logic        gmask = 1'b0;
  logic        irq_a;
  logic        irq_b;
  logic        lvl_a;
  logic        pu_a;
  logic        pu_b;
  logic [31:0] rd;
  logic        serr;
  int          mismatches = 0;
  int          checked = 0;
  int          cyc = 0;
  deil_row_s   rows [4] = '{'{b_adr, 8'hff, 8'h43, 1'b0}, '{b_adr, 8'h00, 8'h00, 1'b1},
                            '{a_adr, 8'hff, 8'h03, 1'b1}, '{b_adr, 8'h43, 8'h43, 1'b0}};

  always #5 pclk = ~pclk;

  deil_src_model deil_src_model_i (.pclk(pclk), .hold_low(low), .pin_a(pin_a), .pin_b(pin_b));
  deil_top deil_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_int_pin_a(pin_a), .ext_int_pin_b(pin_b), .vector_ack_a(vack_a),
    .vector_ack_b(vack_b), .break_state(brk), .break_clear_enable(bce),
    .cpu_int_mask(gmask), .irq_request_a(irq_a), .irq_request_b(irq_b),
    .pin_level_a(lvl_a), .pullup_en_a(pu_a), .pullup_en_b(pu_b));

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // an edge passes first so no signal is assigned twice in one time step
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(a, 1'b0, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask

  task automatic pins(input logic [1:0] l);
    @(posedge pclk);
    low <= l;
    repeat (6) @(posedge pclk);
  endtask

  // one-cycle vector-fetch acknowledge, as the processor gives it
  task automatic vpulse(input logic b);
    @(posedge pclk);
    vack_a <= ~b;
    vack_b <= b;
    @(posedge pclk);
    vack_a <= 1'b0;
    vack_b <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].a, 1'b1, rows[i].w);
      rdc("ctrl", rows[i].a, rows[i].e);
      chk("pullup b", rows[i].pu, pu_b);
    end
    $display("done: register rows");
    pins(2'h3);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("rst b", b_adr, 8'h00);
    rdc("rst a", a_adr, 8'h00);
    chk("pullups", 2'h3, {pu_a, pu_b});
    pins(2'h0);
    $display("done: reset");
    pins(2'h1);
    rdc("a pend", a_adr, 8'h08);
    chk("irq a", 1'b1, irq_a);
    chk("lvl a", 1'b0, lvl_a);
    apb(a_adr, 1'b1, 8'h02);
    rdc("a masked", a_adr, 8'h0a);
    chk("irq a mask", 1'b0, irq_a);
    gmask <= 1'b1;
    apb(a_adr, 1'b1, 8'h00);
    rdc("a gmask", a_adr, 8'h08);
    chk("irq a gmask", 1'b0, irq_a);
    gmask <= 1'b0;
    pins(2'h0);
    rdc("a held", a_adr, 8'h08);
    apb(a_adr, 1'b1, 8'h04);
    rdc("a soft ack", a_adr, 8'h00);
    pins(2'h3);
    pins(2'h0);
    rdc("a again", a_adr, 8'h08);
    vpulse(1'b0);
    rdc("a vec ack", a_adr, 8'h00);
    rdc("b kept", b_adr, 8'h08);
    vpulse(1'b1);
    rdc("b vec ack", b_adr, 8'h00);
    $display("done: edge mode");
    apb(b_adr, 1'b1, 8'h01);
    pins(2'h2);
    chk("lvl a b low", 1'b1, lvl_a);
    apb(b_adr, 1'b1, 8'h05);
    rdc("b ack low", b_adr, 8'h09);
    pins(2'h0);
    rdc("b high", b_adr, 8'h01);
    pins(2'h2);
    pins(2'h0);
    rdc("b latched", b_adr, 8'h09);
    chk("irq b", 1'b1, irq_b);
    apb(b_adr, 1'b1, 8'h05);
    rdc("b ack high", b_adr, 8'h01);
    chk("irq b off", 1'b0, irq_b);
    $display("done: level mode");
    pins(2'h1);
    pins(2'h0);
    brk <= 1'b1;
    apb(a_adr, 1'b1, 8'h04);
    rdc("brk no clr", a_adr, 8'h08);
    bce <= 1'b1;
    apb(a_adr, 1'b1, 8'h04);
    rdc("brk clr", a_adr, 8'h00);
    brk <= 1'b0;
    bce <= 1'b0;
    rdc("after brk", a_adr, 8'h00);
    $display("done: break");
    rdc("unmapped", 12'h000, 8'h00);
    chk("slverr", 1'b1, serr);
    $display("done: unmapped");
    tally_and_finish();
  end
endmodule
`default_nettype wire
